// File: core/fp_power_pkg.sv
/*
  Constants for the front-panel power button control block: clock rate,
  debounce and sequencing times, derived cycle counts, and the state encoding.
  Assumes a single 50 MHz standby clock.
*/
package fp_power_pkg;

  // ----------------------------------------------------------------
  // clock and times
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned DEBOUNCE_MS = 16;
  localparam int unsigned POWER_GOOD_MS = 100;
  localparam int unsigned RESET_HOLD_MS = 10;
  localparam int unsigned FAILSAFE_MIN_MS = 4000;
  localparam int unsigned FAILSAFE_MAX_MS = 5000;

  // ----------------------------------------------------------------
  // derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned POWER_GOOD_CYCLES = POWER_GOOD_MS * CYC_PER_MS;
  localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_MS * CYC_PER_MS;
  // midpoint of the allowed window keeps margin on both sides
  localparam int unsigned FAILSAFE_CYCLES = ((FAILSAFE_MIN_MS + FAILSAFE_MAX_MS) / 2) * CYC_PER_MS;
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PS_OFF      = 3'h0,
    PS_SUPPLY   = 3'h1,
    PS_GOOD     = 3'h3,
    PS_RUNNING  = 3'h2
  } power_state_t;

endpackage

// File: core/button_if.sv
/*
  Carries the debounced power button between the debouncer and the
  sequencer. Assumes both ends share core_clk.
*/
`timescale 1ns/1ps
interface button_if;
  logic pressed;     // debounced level, high while held
  logic pressPulse;  // one cycle on each new press

  modport deb (output pressed, output pressPulse);
  modport ctl (input pressed, input pressPulse);
endinterface

// File: core/button_debounce.sv
/*
  Synchronises and debounces the active-low power button pin and flags
  each new press. Assumes the pin is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module button_debounce
  import fp_power_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_CYCLES
) (
  input wire logic core_clk,         // standby clock
  input wire logic rst,              // synchronous reset
  input wire logic buttonLow,        // raw pin, low when pressed
  button_if.deb btn                  // debounced result
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic stable;
    logic pulse;
    logic [CNT_W-1:0] cnt;
  } deb_t;

  localparam deb_t DEB_RST = '{meta: 1'b1, sync: 1'b1, stable: 1'b1, pulse: 1'b0, cnt: '0};

  deb_t cur_ff;
  deb_t nxt_deb;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_deb = cur_ff;
    nxt_deb.meta = buttonLow;
    nxt_deb.sync = cur_ff.meta;
    nxt_deb.pulse = 1'b0;
    // level must differ for the full window before it is accepted
    if (cur_ff.sync == cur_ff.stable) begin
      nxt_deb.cnt = '0;
    end else if (cur_ff.cnt >= CNT_W'(DEBOUNCE_CYC - 1)) begin
      nxt_deb.cnt = '0;
      nxt_deb.stable = cur_ff.sync;
      nxt_deb.pulse = ~cur_ff.sync;
    end else begin
      nxt_deb.cnt = cur_ff.cnt + CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff <= DEB_RST;
    end else begin
      cur_ff <= nxt_deb;
    end
  end

  assign btn.pressed = ~cur_ff.stable;
  assign btn.pressPulse = cur_ff.pulse;

endmodule

// File: core/front_panel_power_button_control.sv
/*
  Front-panel power button handling inside the management controller:
  debounced button and chipset wake start power-up; chipset off state or a
  failsafe timeout drop the supply request.
  Except to start power-up from off, the button never moves the supply: each debounced press is
  forwarded to the chipset, and only the sequencer below changes the
  supply request, power good and platform reset.
  Power-up runs supply, then power good, then reset release, each step
  timed by one shared phase counter.
  Assumes the chipset power state machine and host firmware sit outside,
  and that all chipset and supply inputs are asynchronous to core_clk.
  Chipset off may read true while rails come up, so it is only used once running.
*/
`timescale 1ns/1ps
module front_panel_power_button_control
  import fp_power_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_CYCLES,
  parameter int unsigned POWER_GOOD_CYC = POWER_GOOD_CYCLES,
  parameter int unsigned RESET_HOLD_CYC = RESET_HOLD_CYCLES,
  parameter int unsigned FAILSAFE_CYC = FAILSAFE_CYCLES
) (
  input wire logic core_clk,               // 50 MHz standby clock
  input wire logic rst,                    // synchronous reset, high
  input wire logic front_power_button_low, // button pin, low when pressed
  input wire logic chipsetWake,            // chipset wake event, high
  input wire logic chipsetOffState,        // chipset reports off state
  input wire logic supplyPowerOk,          // supply rails good
  output logic buttonToChipset,            // forwarded press, one cycle
  output logic supplyOnRequest,            // supply on request, high
  output logic platformPowerGood,          // power good to platform
  output logic platformResetLow,           // platform reset, low active
  output logic failsafeOff,                // pulse when failsafe fired
  output power_state_t powerState          // sequencer state
);

  // ----------------------------------------------------------------
  // button debouncer
  // ----------------------------------------------------------------
  button_if btn ();

  // synchronises the pin and flags each accepted press
  button_debounce #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC)
  ) u_debounce (
    .core_clk(core_clk),
    .rst(rst),
    .buttonLow(front_power_button_low),
    .btn(btn)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    power_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] failCnt;
    logic failArmed;
    logic wakeMeta;
    logic wakeSync;
    logic wakePrev;
    logic offMeta;
    logic offSync;
    logic okMeta;
    logic okSync;
    logic fwd;
    logic supplyOn;
    logic powerGood;
    logic resetLow;
    logic failPulse;
  } ctl_t;

  localparam ctl_t CTL_RST = '{
    state: PS_OFF,
    cnt: '0,
    failCnt: '0,
    failArmed: 1'b0,
    wakeMeta: 1'b0,
    wakeSync: 1'b0,
    wakePrev: 1'b0,
    offMeta: 1'b1,      // chipset reads off at rest
    offSync: 1'b1,
    okMeta: 1'b0,
    okSync: 1'b0,
    fwd: 1'b0,
    supplyOn: 1'b0,
    powerGood: 1'b0,
    resetLow: 1'b0,     // platform held in reset
    failPulse: 1'b0
  };

  // registered state and its next value
  ctl_t cur_ff;
  ctl_t nxt_ctl;
  // decoded conditions
  logic wakeEdge;
  logic failDone;

  // wake transition seen on the synchronised level only
  assign wakeEdge = cur_ff.wakeSync & ~cur_ff.wakePrev;
  // failsafe expiry, only while armed
  assign failDone = cur_ff.failArmed && (cur_ff.failCnt >= CNT_W'(FAILSAFE_CYC - 1));

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctl = cur_ff;
    // two-flop synchronisers for pins from other domains
    nxt_ctl.wakeMeta = chipsetWake;
    nxt_ctl.wakeSync = cur_ff.wakeMeta;
    nxt_ctl.wakePrev = cur_ff.wakeSync;
    nxt_ctl.offMeta = chipsetOffState;
    nxt_ctl.offSync = cur_ff.offMeta;
    nxt_ctl.okMeta = supplyPowerOk;
    nxt_ctl.okSync = cur_ff.okMeta;
    // every press goes to the chipset; in off it also starts power-up
    nxt_ctl.fwd = btn.pressPulse;
    // failsafe flag lasts one cycle
    nxt_ctl.failPulse = 1'b0;
    // phase counter runs freely; entry to supply and to power good reloads it, and it is held at zero in supply while rails are not good
    nxt_ctl.cnt = cur_ff.cnt + CNT_W'(1);
    // failsafe timer runs from the press while on
    if (cur_ff.failArmed) begin
      nxt_ctl.failCnt = cur_ff.failCnt + CNT_W'(1);
    end
    case (cur_ff.state)
      PS_OFF: begin
        // supply request, power good and reset held low; chipset off is not looked at here
        nxt_ctl.supplyOn = 1'b0;
        nxt_ctl.powerGood = 1'b0;
        nxt_ctl.resetLow = 1'b0;
        nxt_ctl.failArmed = 1'b0;
        nxt_ctl.failCnt = '0;
        // either source starts power-up
        if (btn.pressPulse || wakeEdge) begin
          nxt_ctl.state = PS_SUPPLY;
          nxt_ctl.supplyOn = 1'b1;
          nxt_ctl.cnt = '0;
        end
      end
      PS_SUPPLY: begin
        // wait for rails, then settle before power good
        if (!cur_ff.okSync) begin
          nxt_ctl.cnt = '0;
        end else if (cur_ff.cnt >= CNT_W'(POWER_GOOD_CYC - 1)) begin
          nxt_ctl.state = PS_GOOD;
          nxt_ctl.powerGood = 1'b1;
          nxt_ctl.cnt = '0;
        end
      end
      PS_GOOD: begin
        // hold reset after power good, then release;
        // rails lost before release drop straight back to off
        if (!cur_ff.okSync) begin
          nxt_ctl.state = PS_OFF;
          nxt_ctl.supplyOn = 1'b0;
          nxt_ctl.powerGood = 1'b0;
        end else if (cur_ff.cnt >= CNT_W'(RESET_HOLD_CYC - 1)) begin
          nxt_ctl.state = PS_RUNNING;
          nxt_ctl.resetLow = 1'b1;
        end
      end
      PS_RUNNING: begin
        // first press arms the failsafe; later ones do not restart it
        if (btn.pressPulse && !cur_ff.failArmed) begin
          nxt_ctl.failArmed = 1'b1;
          nxt_ctl.failCnt = '0;
        end
        // chipset off wins over an expiring failsafe
        if (cur_ff.offSync || !cur_ff.okSync) begin
          nxt_ctl.state = PS_OFF;
          nxt_ctl.supplyOn = 1'b0;
          nxt_ctl.powerGood = 1'b0;
          nxt_ctl.resetLow = 1'b0;
          nxt_ctl.failArmed = 1'b0;
        end else if (failDone) begin
          // firmware never serviced the press
          nxt_ctl.state = PS_OFF;
          nxt_ctl.supplyOn = 1'b0;
          nxt_ctl.powerGood = 1'b0;
          nxt_ctl.resetLow = 1'b0;
          nxt_ctl.failArmed = 1'b0;
          nxt_ctl.failPulse = 1'b1;
        end
      end
      default: begin
        // unused codes recover to off
        nxt_ctl = CTL_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // synchronous reset to the idle, supply-off state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff <= CTL_RST;
    end else begin
      cur_ff <= nxt_ctl;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output comes straight from a flop
  assign buttonToChipset = cur_ff.fwd;
  assign supplyOnRequest = cur_ff.supplyOn;
  assign platformPowerGood = cur_ff.powerGood;
  assign platformResetLow = cur_ff.resetLow;
  assign failsafeOff = cur_ff.failPulse;
  assign powerState = cur_ff.state;

endmodule

// File: sim/fp_power_checker.sv
/*
  Port assertions for the power button block.
  Assumes shortened counts from the bench; bound at the foot.
*/
`timescale 1ns/1ps
module fp_power_checker
  import fp_power_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = 4,
  parameter int unsigned POWER_GOOD_CYC = 8,
  parameter int unsigned RESET_HOLD_CYC = 4,
  parameter int unsigned FAILSAFE_CYC = 40
) (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic front_power_button_low, // pin
  input wire logic chipsetWake, // wake
  input wire logic chipsetOffState, // chipset off
  input wire logic supplyPowerOk, // rails good
  input wire logic buttonToChipset, // press out
  input wire logic supplyOnRequest, // supply
  input wire logic platformPowerGood, // good
  input wire logic platformResetLow, // reset out
  input wire logic failsafeOff, // failsafe
  input wire power_state_t powerState // state
);
  logic [5:0] offHist_ff;
  // recent chipset off or rail loss
  always_ff @(posedge core_clk) begin
    offHist_ff <= {offHist_ff[4:0], chipsetOffState || !supplyPowerOk};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_press_debounced: assert property (
    buttonToChipset |-> !$past(front_power_button_low, 5) && !$past(front_power_button_low, DEBOUNCE_CYC + 2))
    else $error("press without debounced pin");
  a_press_no_switch: assert property (
    buttonToChipset && powerState == PS_RUNNING |=> supplyOnRequest)
    else $error("press switched supply");
  a_supply_drop: assert property (
    $fell(supplyOnRequest) |-> failsafeOff || (|offHist_ff))
    else $error("supply dropped without cause");
  a_supply_start: assert property (
    $rose(supplyOnRequest) |-> $past(powerState) == PS_OFF && powerState == PS_SUPPLY)
    else $error("supply rose outside off");
  a_wake_start: assert property (
    powerState == PS_OFF && $rose(chipsetWake) |-> ##[1:6] supplyOnRequest)
    else $error("wake ignored");
  a_good_order: assert property (
    $rose(platformPowerGood) |-> powerState == PS_GOOD && $past(supplyOnRequest, POWER_GOOD_CYC))
    else $error("power good early");
  a_reset_hold: assert property (
    $rose(platformResetLow) |-> powerState == PS_RUNNING && $past(platformPowerGood, RESET_HOLD_CYC)
      && !$past(platformPowerGood, RESET_HOLD_CYC + 1))
    else $error("reset released early");
  a_failsafe_off: assert property (
    failsafeOff |-> !supplyOnRequest && $past(powerState, FAILSAFE_CYC) == PS_RUNNING)
    else $error("failsafe wrong");
  // main scenarios
  c_wake: cover property (powerState == PS_OFF && $rose(chipsetWake));
  c_off: cover property ($fell(supplyOnRequest) && !failsafeOff);
  c_failsafe: cover property (failsafeOff);
endmodule

bind front_panel_power_button_control fp_power_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC),
  .POWER_GOOD_CYC(POWER_GOOD_CYC), .RESET_HOLD_CYC(RESET_HOLD_CYC), .FAILSAFE_CYC(FAILSAFE_CYC))
  fp_power_checker_i (.core_clk(core_clk), .rst(rst), .front_power_button_low(front_power_button_low),
  .chipsetWake(chipsetWake), .chipsetOffState(chipsetOffState), .supplyPowerOk(supplyPowerOk),
  .buttonToChipset(buttonToChipset), .supplyOnRequest(supplyOnRequest), .platformPowerGood(platformPowerGood),
  .platformResetLow(platformResetLow), .failsafeOff(failsafeOff), .powerState(powerState));

// File: sim/chipset_model.sv
/*
  Chipset power state machine, firmware and supply.
  Assumes the block's outputs on the same clock.
*/
`timescale 1ns/1ps
module chipset_model (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic buttonToChipset, // forwarded press
  input wire logic supplyOnRequest, // supply request
  input wire logic serviceEn, // firmware services presses
  output logic chipsetOffState, // off state
  output logic supplyPowerOk // rails good
);
  logic [3:0] okCnt_ff;
  logic [3:0] svcCnt_ff;
  // rails good some cycles after request
  always_ff @(posedge core_clk) begin
    if (rst || !supplyOnRequest) begin
      okCnt_ff <= 4'h0;
    end else if (okCnt_ff != 4'hF) begin
      okCnt_ff <= okCnt_ff + 4'h1;
    end
  end
  assign supplyPowerOk = okCnt_ff > 4'h3;
  // serviced press sets off state after a delay
  always_ff @(posedge core_clk) begin
    if (rst || !supplyOnRequest) begin
      svcCnt_ff <= 4'h0;
    end else if (buttonToChipset && serviceEn) begin
      svcCnt_ff <= 4'h1;
    end else if (svcCnt_ff != 4'h0 && svcCnt_ff != 4'hF) begin
      svcCnt_ff <= svcCnt_ff + 4'h1;
    end
  end
  assign chipsetOffState = !supplyOnRequest || svcCnt_ff == 4'hF;
endmodule

// File: sim/tb.sv
/*
  Self-checking bench for the power button block.
  Assumes the chipset model and shortened counts.
*/
`timescale 1ns/1ps
module tb;
  import fp_power_pkg::*;
  localparam int DB = 4;
  localparam int FS = 40;
  logic core_clk = 1'b0, rst = 1'b1, pinLow = 1'b1, wake = 1'b0, svcEn = 1'b0;
  logic offSt, powerOk, toChip, supReq, good, rstLow, fsOff;
  logic [31:0] seed = 32'h0000005F;
  power_state_t state;
  int bad_count = 0, check_count = 0, pulses = 0, since = 0, fsAt = 0, fsCnt = 0, i;
  always #10 core_clk = ~core_clk;
  // press and failsafe bookkeeping
  always @(posedge core_clk) begin
    pulses <= pulses + int'(toChip === 1'b1);
    since <= (toChip === 1'b1) ? 0 : since + 1;
    if (fsOff === 1'b1) begin
      fsAt <= since;
      fsCnt <= fsCnt + 1;
    end
  end
  front_panel_power_button_control #(.DEBOUNCE_CYC(DB), .POWER_GOOD_CYC(8), .RESET_HOLD_CYC(4),
    .FAILSAFE_CYC(FS)) front_panel_power_button_control_i (.core_clk(core_clk), .rst(rst),
    .front_power_button_low(pinLow), .chipsetWake(wake), .chipsetOffState(offSt),
    .supplyPowerOk(powerOk), .buttonToChipset(toChip), .supplyOnRequest(supReq),
    .platformPowerGood(good), .platformResetLow(rstLow), .failsafeOff(fsOff), .powerState(state));
  chipset_model chipset_model_i (.core_clk(core_clk), .rst(rst), .buttonToChipset(toChip),
    .supplyOnRequest(supReq), .serviceEn(svcEn), .chipsetOffState(offSt), .supplyPowerOk(powerOk));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  function automatic int expPulse(input int n);
    return int'(n >= DB);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d bad=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hold the pin low n cycles, release, let it settle
  task automatic press(input int n);
    int p0;
    p0 = pulses;
    @(posedge core_clk) pinLow <= 1'b0;
    repeat (n) @(posedge core_clk);
    pinLow <= 1'b1;
    repeat (2 * DB + 8) @(posedge core_clk);
    chk(pulses - p0, expPulse(n));
  endtask
  task automatic wait_state(input power_state_t s);
    for (i = 0; i < 400 && state !== s; i++) @(posedge core_clk);
    if (state !== s) begin
      chk(state, s);
      finish_test();
    end
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk({state, supReq, good, rstLow, fsOff, toChip}, 8'h00);
    press(DB - 1);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      press(1 + int'(seed % (DB - 1)));
      chk(supReq, 1'b0);
    end
    press(DB);
    wait_state(PS_RUNNING);
    chk({good, rstLow, supReq}, 3'h7);
    repeat (5) @(posedge core_clk);
    svcEn <= 1'b1;
    seed = xs(seed);
    press(DB + 3 + int'(seed % 4));
    wait_state(PS_OFF);
    chk(fsCnt, 0);
    chk({supReq, good, rstLow}, 3'h0);
    svcEn <= 1'b0;
    repeat (5) @(posedge core_clk);
    wake <= 1'b1;
    wait_state(PS_RUNNING);
    chk({good, rstLow}, 2'h3);
    wake <= 1'b0;
    repeat (5) @(posedge core_clk);
    press(DB + 3);
    for (i = 0; i < 4 * FS && fsCnt == 0; i++) @(posedge core_clk);
    @(posedge core_clk);
    chk(fsCnt, 1);
    chk(fsAt >= FS - 2 && fsAt <= FS + 2, 1'b1);
    chk({state, supReq, good, rstLow}, 6'h00);
    finish_test();
  end
endmodule
